// ### rtl/epd_decode.sv
// Overview of operation
// - opcode e8 with select 0..2 adds six-bit literal to that pointer, one cycle
// - select 3 adds literal to stack-frame pointer, then returns through stack top
// - add-and-return takes two cycles, second is a dead cycle
// - opcode 0014 calls through working register in two cycles, no flags
// - eb with bit7 low then f-word moves frame+offset to absolute address, two cycles
// - eb with bit7 high then f-word moves frame+offset to frame+offset, two cycles
// - opcode ea pushes literal to software stack in one cycle
// - opcode e9 subtracts six-bit literal from selected pointer, one cycle
// - e9 with select 3 subtracts from frame pointer then returns, two cycles
// - call pushes next address and loads pc from working reg and latches
// - literal push writes at frame pointer address then decrements it by one
// - extension words are taken only while enable bit is set, except a move's second word; set by default
`timescale 1ns/1ns
`default_nettype none
module epd_decode (
  input wire logic sys_clk_i, // core clock
  input wire logic rst_b_i, // async reset, low active
  input wire logic instr_valid_i, // instruction word present
  input wire logic [15:0] instr_i, // fetched instruction word
  input wire logic ext_enable_i, // extension enable bit
  input wire logic [7:0] working_reg_i, // working register
  input wire logic [7:0] pc_high_latch_i, // program counter high latch
  input wire logic [4:0] pc_upper_latch_i, // program counter upper latch
  input wire logic [20:0] stack_top_i, // return stack top
  input wire logic [7:0] mem_rdata_i, // data memory read data
  output logic [2:0][11:0] ptr_o, // indirect pointers
  output logic [20:0] pc_o, // program counter
  output logic [4:0] rsp_o, // return stack pointer
  output epd_pkg::epd_mem_t mem_o, // data memory access
  output epd_pkg::epd_stack_t stack_o, // return stack control
  output logic flush_o, // fetched word discarded
  output logic ext_hit_o // extension instruction taken
);
  import epd_pkg::*;

  epd_regs_t r, next_r;
  logic [1:0] sel;
  logic [11:0] lit6;

  assign sel = instr_i[7:6];
  assign lit6 = {6'h00, instr_i[5:0]};

  // ---------------------------------------------------------
  // next state
  // ---------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.mem = '0;
    next_r.stk = '0;
    next_r.hit = 1'b0;
    case (r.st)
      EPD_ST_DEAD: begin
        next_r.st = EPD_ST_FETCH;
      end
      EPD_ST_MOVE2: begin
        // any valid word completes the move; its top nibble is not checked
        if (instr_valid_i) begin
          next_r.st = EPD_ST_FETCH;
          next_r.pc = r.pc + PC_STEP;
          next_r.mem.we = 1'b1;
          next_r.mem.wdata = mem_rdata_i;
          next_r.hit = 1'b1;
          if (r.move_ss) begin
            next_r.mem.addr = r.ptr[FRAME_PTR_IDX] + {5'h00, instr_i[6:0]};
          end else begin
            next_r.mem.addr = instr_i[11:0];
          end
        end
      end
      default: begin
        if (instr_valid_i && ext_enable_i) begin
          next_r.pc = r.pc + PC_STEP;
          next_r.hit = 1'b1;
          if (instr_i[15:8] == OPC_ADD_HI || instr_i[15:8] == OPC_SUB_HI) begin
            if (sel == SEL_FRAME_RET) begin
              if (instr_i[8]) begin
                next_r.ptr[FRAME_PTR_IDX] = r.ptr[FRAME_PTR_IDX] - lit6;
              end else begin
                next_r.ptr[FRAME_PTR_IDX] = r.ptr[FRAME_PTR_IDX] + lit6;
              end
              next_r.pc = stack_top_i;
              next_r.stk.pop = 1'b1;
              next_r.rsp = r.rsp - 5'h01;
              next_r.st = EPD_ST_DEAD;
            end else if (instr_i[8]) begin
              next_r.ptr[sel] = r.ptr[sel] - lit6;
            end else begin
              next_r.ptr[sel] = r.ptr[sel] + lit6;
            end
          end else if (instr_i[15:8] == OPC_PUSH_HI) begin
            next_r.mem.we = 1'b1;
            next_r.mem.addr = r.ptr[FRAME_PTR_IDX];
            next_r.mem.wdata = instr_i[7:0];
            next_r.ptr[FRAME_PTR_IDX] = r.ptr[FRAME_PTR_IDX] - PUSH_STEP;
          end else if (instr_i[15:8] == OPC_MOVE_HI) begin
            next_r.move_ss = instr_i[7];
            next_r.mem.re = 1'b1;
            next_r.mem.addr = r.ptr[FRAME_PTR_IDX] + {5'h00, instr_i[6:0]};
            next_r.src_addr = next_r.mem.addr;
            next_r.st = EPD_ST_MOVE2;
          end else if (instr_i == OPC_CALL_WORKING) begin
            next_r.stk.push = 1'b1;
            next_r.stk.push_data = r.pc + PC_STEP;
            next_r.rsp = r.rsp + 5'h01;
            next_r.pc = {pc_upper_latch_i, pc_high_latch_i, working_reg_i};
            next_r.st = EPD_ST_DEAD;
          end else begin
            next_r.hit = 1'b0;
            next_r.pc = r.pc;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------
  // state register
  // ---------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{
        st: EPD_ST_FETCH,
        ptr: {3{PTR_RESET}},
        pc: PC_RESET,
        rsp: RSP_RESET,
        default: '0
      };
    end else begin
      r <= next_r;
    end
  end

  assign ptr_o = r.ptr;
  assign pc_o = r.pc;
  assign rsp_o = r.rsp;
  assign mem_o = r.mem;
  assign stack_o = r.stk;
  assign flush_o = (r.st == EPD_ST_DEAD);
  assign ext_hit_o = r.hit;

  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  add_ptr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i[15:8] == OPC_ADD_HI
      && instr_i[7:6] == 2'h0) |=> ptr_o[0] == $past(r.ptr[0]) + {6'h00, $past(instr_i[5:0])})
    else $error("add to pointer wrong");
  sub_ptr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i[15:8] == OPC_SUB_HI
      && instr_i[7:6] == 2'h1) |=> ptr_o[1] == $past(r.ptr[1]) - {6'h00, $past(instr_i[5:0])})
    else $error("subtract from pointer wrong");
  ret_pop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    stack_o.pop |-> pc_o == $past(stack_top_i) && rsp_o == $past(r.rsp) - 5'h01)
    else $error("return did not pop");
  ret_dead_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    stack_o.pop |-> flush_o ##1 !flush_o)
    else $error("return not two cycles");
  call_pc_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    stack_o.push |-> stack_o.push_data == $past(r.pc) + 21'h000002
      && pc_o[7:0] == $past(working_reg_i) && flush_o)
    else $error("call through working reg wrong");
  push_dec_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i[15:8] == OPC_PUSH_HI)
      |=> mem_o.we && mem_o.addr == $past(r.ptr[2]) && ptr_o[2] == mem_o.addr - 12'h001)
    else $error("literal push wrong");
  move_two_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mem_o.re && r.st == EPD_ST_MOVE2 && !r.move_ss && instr_valid_i)
      |=> mem_o.we && mem_o.addr == $past(instr_i[11:0]))
    else $error("absolute move wrong");
  gate_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && !ext_enable_i) |=> !ext_hit_o && $stable(ptr_o))
    else $error("extension ran while disabled");
  frame_ret_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i[15:8] == OPC_ADD_HI
      && instr_i[7:6] == SEL_FRAME_RET)
      |=> stack_o.pop && ptr_o[2] == $past(r.ptr[2]) + {6'h00, $past(instr_i[5:0])})
    else $error("add and return wrong");
  sub_ret_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i[15:8] == OPC_SUB_HI
      && instr_i[7:6] == SEL_FRAME_RET)
      |=> stack_o.pop && ptr_o[2] == $past(r.ptr[2]) - {6'h00, $past(instr_i[5:0])})
    else $error("subtract and return wrong");
  push_data_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i[15:8] == OPC_PUSH_HI)
      |=> mem_o.wdata == $past(instr_i[7:0]) && ext_hit_o && !flush_o)
    else $error("literal push data wrong");
  call_two_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r.st == EPD_ST_FETCH && instr_valid_i && ext_enable_i && instr_i == OPC_CALL_WORKING)
      |=> stack_o.push && flush_o ##1 !flush_o && !ext_hit_o)
    else $error("call not two cycles");
  dead_ignore_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    flush_o |=> !ext_hit_o && $stable(ptr_o) && !mem_o.we)
    else $error("dead cycle executed a word");
  move_index_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mem_o.re && r.st == EPD_ST_MOVE2 && r.move_ss && instr_valid_i)
      |=> mem_o.we && mem_o.wdata == $past(mem_rdata_i)
      && mem_o.addr == ptr_o[2] + {5'h00, $past(instr_i[6:0])})
    else $error("indexed move wrong");

  // ---------------------------------------------------------
  // cover points
  // ---------------------------------------------------------
  ret_cov_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) stack_o.pop);
  call_cov_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) stack_o.push);
  move_cov_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    mem_o.re ##1 mem_o.we);
  gate_cov_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    r.st == EPD_ST_FETCH && instr_valid_i && !ext_enable_i);
  index_cov_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    mem_o.re && r.move_ss);
endmodule // epd_decode
`default_nettype wire

// ### rtl/epd_pkg.sv
package epd_pkg;
  localparam logic [7:0] OPC_ADD_HI = 8'he8;
  localparam logic [7:0] OPC_SUB_HI = 8'he9;
  localparam logic [7:0] OPC_PUSH_HI = 8'hea;
  localparam logic [7:0] OPC_MOVE_HI = 8'heb;
  localparam logic [3:0] OPC_SECOND_HI = 4'hf;
  localparam logic [15:0] OPC_CALL_WORKING = 16'h0014;
  localparam logic [1:0] SEL_FRAME_RET = 2'h3;
  localparam logic [1:0] FRAME_PTR_IDX = 2'h2;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [11:0] PUSH_STEP = 12'h001;
  localparam logic [4:0] RSP_RESET = 5'h00;

  typedef enum logic [1:0] {
    EPD_ST_FETCH = 2'b00,
    EPD_ST_DEAD = 2'b01,
    EPD_ST_MOVE2 = 2'b10
  } epd_state_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic re;
  } epd_mem_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [20:0] push_data;
  } epd_stack_t;

  typedef struct packed {
    epd_state_t st;
    logic [2:0][11:0] ptr;
    logic [20:0] pc;
    logic [4:0] rsp;
    logic move_ss;
    logic [11:0] src_addr;
    epd_mem_t mem;
    epd_stack_t stk;
    logic hit;
  } epd_regs_t;
endpackage

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import epd_pkg::*;
  typedef struct packed {logic [15:0] w; logic [11:0] p0;
    logic [11:0] p1; logic [11:0] p2;} epd_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic ext_enable_i = 1'b1;
  logic [7:0] working_reg_i = 8'h06;
  logic [7:0] pc_high_latch_i = 8'h10;
  logic [4:0] pc_upper_latch_i = 5'h03;
  logic [20:0] stack_top_i = 21'h1abcde;
  logic [7:0] mem_rdata_i = 8'h5a;
  logic [2:0][11:0] ptr_o;
  logic [20:0] pc_o;
  logic [4:0] rsp_o;
  epd_mem_t mem_o;
  epd_stack_t stack_o;
  logic flush_o;
  logic ext_hit_o;
  logic [20:0] e_pc;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // one-cycle pointer ops, back to back
  epd_row_t rows [8] = '{'{16'he805, 12'h005, 12'h000, 12'h000},
    '{16'he87f, 12'h005, 12'h03f, 12'h000}, '{16'he8bf, 12'h005, 12'h03f, 12'h03f},
    '{16'he903, 12'h002, 12'h03f, 12'h03f}, '{16'he941, 12'h002, 12'h03e, 12'h03f},
    '{16'he981, 12'h002, 12'h03e, 12'h03e}, '{16'heaa5, 12'h002, 12'h03e, 12'h03d},
    '{16'he900, 12'h002, 12'h03e, 12'h03d}};

  epd_decode i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .ext_enable_i(ext_enable_i), .working_reg_i(working_reg_i),
    .pc_high_latch_i(pc_high_latch_i), .pc_upper_latch_i(pc_upper_latch_i),
    .stack_top_i(stack_top_i), .mem_rdata_i(mem_rdata_i), .ptr_o(ptr_o), .pc_o(pc_o),
    .rsp_o(rsp_o), .mem_o(mem_o), .stack_o(stack_o), .flush_o(flush_o), .ext_hit_o(ext_hit_o));

  always #4 sys_clk_i = ~sys_clk_i;

  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // present a word at the falling edge, look half a cycle after the taking edge
  task automatic step(input logic v, input logic [15:0] w);
    instr_valid_i = v;
    instr_i = w;
    @(negedge sys_clk_i);
  endtask

  initial begin
    repeat (16) @(negedge sys_clk_i);
    chk({pc_o, ptr_o, rsp_o}, 64'h0);
    chk({mem_o, stack_o, ext_hit_o, flush_o}, 64'h0);
    rst_b_i = 1'b1;
    e_pc = 21'h000000;
    foreach (rows[i]) begin
      step(1'b1, rows[i].w);
      e_pc = e_pc + 21'h000002;
      chk(ptr_o, {rows[i].p2, rows[i].p1, rows[i].p0});
      chk({pc_o, ext_hit_o}, {e_pc, 1'b1});
      if (rows[i].w[15:8] == OPC_PUSH_HI) begin
        chk({mem_o.we, mem_o.addr, mem_o.wdata}, {1'b1, 12'h03e, 8'ha5});
      end else begin
        chk(mem_o.we, 64'h0);
      end
    end
    step(1'b1, 16'he8c3);
    chk({ptr_o[2], pc_o, rsp_o}, {12'h040, 21'h1abcde, 5'h1f});
    chk({stack_o.pop, flush_o}, 2'b11);
    step(1'b1, 16'he805);
    chk({ptr_o[0], flush_o, ext_hit_o, pc_o}, {12'h002, 2'b00, 21'h1abcde});
    step(1'b1, 16'he9c1);
    chk({ptr_o[2], pc_o, rsp_o}, {12'h03f, 21'h1abcde, 5'h1e});
    chk({stack_o.pop, flush_o}, 2'b11);
    step(1'b0, 16'h0000);
    step(1'b1, OPC_CALL_WORKING);
    chk({pc_o, stack_o.push, flush_o}, {21'h031006, 2'b11});
    chk(stack_o.push_data, 21'h1abce0);
    chk(rsp_o, 64'h1f);
    step(1'b0, 16'h0000);
    step(1'b1, 16'heb05);
    chk({mem_o.re, mem_o.addr, flush_o}, {1'b1, 12'h044, 1'b0});
    step(1'b1, 16'hf123);
    chk({mem_o.we, mem_o.addr, mem_o.wdata, pc_o}, {1'b1, 12'h123, 8'h5a, 21'h03100a});
    step(1'b1, 16'heb85);
    chk({mem_o.re, mem_o.addr}, {1'b1, 12'h044});
    step(1'b1, 16'hf007);
    chk({mem_o.we, mem_o.addr, mem_o.wdata, pc_o}, {1'b1, 12'h046, 8'h5a, 21'h03100e});
    ext_enable_i = 1'b0;
    step(1'b1, 16'he805);
    chk({ext_hit_o, ptr_o[0], pc_o}, {1'b0, 12'h002, 21'h03100e});
    ext_enable_i = 1'b1;
    step(1'b1, 16'h0000);
    chk({ext_hit_o, ptr_o[0], pc_o}, {1'b0, 12'h002, 21'h03100e});
    step(1'b0, 16'h0000);
    // reset in mid-move clears the pending second word
    step(1'b1, 16'heb05);
    rst_b_i = 1'b0;
    step(1'b0, 16'h0000);
    chk({pc_o, ptr_o, rsp_o}, 64'h0);
    chk({mem_o, stack_o, ext_hit_o, flush_o}, 64'h0);
    rst_b_i = 1'b1;
    step(1'b1, 16'he805);
    chk({ptr_o[0], pc_o, ext_hit_o, mem_o.we}, {12'h005, 21'h000002, 2'b10});
    step(1'b0, 16'h0000);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
